// [verilog/pcc_params.svh]
// Register offsets, field positions, reset values and counts of the pulse counter
`ifndef PCC_PARAMS_SVH
`define PCC_PARAMS_SVH
`define PCC_A_CTRL 8'h00
`define PCC_A_CMD 8'h04
`define PCC_A_STATUS 8'h08
`define PCC_A_CNT 8'h0C
`define PCC_A_TOP 8'h10
`define PCC_A_TOPB 8'h14
`define PCC_A_IF 8'h18
`define PCC_A_IFS 8'h1C
`define PCC_A_IFC 8'h20
`define PCC_A_IEN 8'h24
`define PCC_A_ROUTE 8'h28
`define PCC_A_FREEZE 8'h2C
`define PCC_A_SYNC 8'h30
`define PCC_A_AUX 8'h38
`define PCC_A_INPUT 8'h3C
`define PCC_F_MODE 1:0
`define PCC_F_CNTDIR 2
`define PCC_F_EDGE 3
`define PCC_F_PULSE_FILTER_ENABLE 4
`define PCC_F_DOMAIN_RESET_BIT 5
`define PCC_F_AUXRST 6
`define PCC_F_S1CDIR 8
`define PCC_F_AUXEV 15:14
`define PCC_F_CC_TRIGGER_MODE 19:18
`define PCC_F_CC_PRESCALER 23:22
`define PCC_F_CC_COMPARE_MODE 26:25
`define PCC_F_GATE 27
`define PCC_F_TPOL 28
`define PCC_F_TSEL 31:29
`define PCC_F_ISEL 2:0
`define PCC_F_IEN0 4
`define PCC_F_IEN1 5
`define PCC_I_UF 0
`define PCC_I_OF 1
`define PCC_I_CM 2
`define PCC_I_DC 3
`define PCC_I_AUXOF 4
`define PCC_B_CTRL 0
`define PCC_B_CMD 1
`define PCC_B_TOPB 2
`define PCC_MODE_OVS 2'h1
`define PCC_MODE_EXTS 2'h2
`define PCC_MODE_EXTQ 2'h3
`define PCC_TCC_LF 2'h1
`define PCC_TCC_EV 2'h2
`define PCC_CMP_LE 2'h0
`define PCC_CMP_GE 2'h1
`define PCC_CMP_RANGE 2'h2
`define PCC_TOP_RST 16'h00FF
`define PCC_CNT_MAX 16'hFFFF
`define PCC_PULSE_FILTER_ENABLE_STABLE 3'h4
`define PCC_SYNC_EDGES 2'h2
`define PCC_REL_EDGES 2'h2
`define PCC_LAST_CHAN 3'h5
`endif

// [verilog/pcc_pkg.sv]
// State type of the pulse counter
package pcc_pkg;
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] ctrl_eff;
        logic [15:0] topb;
        logic [15:0] top;
        logic [15:0] cnt;
        logic [15:0] aux;
        logic [4:0] iflags;
        logic [4:0] ien;
        logic [1:0] route;
        logic freeze;
        logic [5:0] inp;
        logic [2:0] busy;
        logic [1:0] sync_cnt;
        logic [1:0] rel;
        logic [1:0] aux_rel;
        logic [1:0] lf_s;
        logic [1:0] s0_s;
        logic [1:0] s1_s;
        logic [5:0] ev_a;
        logic [5:0] ev_b;
        logic lf_prev;
        logic s0_prev;
        logic trig_prev;
        logic samp_last;
        logic [2:0] stab;
        logic pulse_filter_enable;
        logic [2:0] presc;
        logic qa;
        logic dir;
        logic cc_pend;
        logic cmp_out;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } pcc_state_s;
endpackage : pcc_pkg

// [verilog/pcc_pulse_counter.sv]
// Pulse counter with compare-and-clear, domain reset and APB registers
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`include "pcc_params.svh"
// How it works
// - An enabled trigger compares count with top, then clears count.
// - Low-frequency trigger fires once every 2^N low-frequency ticks.
// - Event trigger comes from channel 0..5 chosen by a 3-bit field.
// - Polarity 0 triggers on rising edge, 1 on falling edge.
// - Gate enable stops counter ticks and register commits when low.
// - Three compare modes against top: below, above, range.
// - Match sets flag and event output, held until next trigger.
// - With compare-and-clear, no wrap at top; stop at max, flag.
// - Count pulse and trigger never coincide; trigger waits a cycle.
// - Written control, command and top buffer values commit after two counter-domain ticks.
// - Reset bit holds counter domain; release two ticks after clear.
// - Secondary reset bit resets secondary counter; domain reset too.
// - Oversampled filter passes level after 5 stable samples.
// - Oversampled mode counts rising, or falling with edge bit.
// - Edge bit inverts quadrature direction; none in ext single.
// - Input enable bits route an event channel to either input.
// - Down pulse at zero sets underflow and loads top.
// - Up pulse at top sets overflow and loads zero.
// - Quadrature direction change sets its flag.
// - Trigger mode: 0 off, 1 low-frequency, 2 event channel.
// - Prescaler 0..3 gives trigger every 1, 2, 4 or 8 ticks.
// - Compare mode 0 below, 1 above, 2 range top[7:0]..top[15:8].
module pcc_pulse_counter
    import pcc_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic low_freq_clock_in,
    input wire logic first_pulse_input_in,
    input wire logic second_pulse_input_in,
    input wire logic [5:0] event_channel_in,
    output logic compare_event_out
);
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic chan_pick(input logic [5:0] ch, input logic [2:0] sel);
        chan_pick = (sel <= `PCC_LAST_CHAN) ? ch[sel] : 1'b0;
    endfunction : chan_pick

    function automatic logic cmp_hit(input logic [1:0] m, input logic [15:0] c,
                                     input logic [15:0] t);
        case (m)
            `PCC_CMP_LE: cmp_hit = c <= t;
            `PCC_CMP_GE: cmp_hit = c >= t;
            `PCC_CMP_RANGE: cmp_hit = (c <= {8'h00, t[15:8]}) && (c >= {8'h00, t[7:0]});
            default: cmp_hit = 1'b0;
        endcase
    endfunction : cmp_hit

    pcc_state_s q;
    pcc_state_s d;
    logic wr, rd_ok, wr_ctrl, dom_rst, aux_rst, lf_rise, s0_src, s1_src, s0_rise, s0_fall;
    logic gate_open, ctr_tick, cnt_pulse, down, tcc_on, cc_raw, cc_req, cc_fire;
    logic match, commit, trig, quad, edge_now;
    logic [1:0] mode;
    logic [3:0] msk;
    logic [4:0] hw_set;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        d = q;
        hw_set = 5'h00;
        d.lf_s = {q.lf_s[0], low_freq_clock_in};
        d.s0_s = {q.s0_s[0], first_pulse_input_in};
        d.s1_s = {q.s1_s[0], second_pulse_input_in};
        d.ev_a = event_channel_in;
        d.ev_b = q.ev_a;
        d.lf_prev = q.lf_s[1];
        mode = q.ctrl_eff[`PCC_F_MODE];
        quad = mode == `PCC_MODE_EXTQ;
        dom_rst = q.ctrl[`PCC_F_DOMAIN_RESET_BIT] | (q.rel != `PCC_REL_EDGES);
        aux_rst = dom_rst | q.ctrl[`PCC_F_AUXRST] | (q.aux_rel != `PCC_REL_EDGES);
        lf_rise = q.lf_s[1] & ~q.lf_prev;
        // Event routing onto either input
        s0_src = q.inp[`PCC_F_IEN0] ? chan_pick(q.ev_b, q.inp[`PCC_F_ISEL]) : q.s0_s[1];
        s1_src = q.inp[`PCC_F_IEN1] ? chan_pick(q.ev_b, q.inp[`PCC_F_ISEL]) : q.s1_s[1];
        d.s0_prev = s0_src;
        s0_rise = s0_src & ~q.s0_prev;
        s0_fall = ~s0_src & q.s0_prev;
        // Gate shared by counting, low-frequency trigger and register commits
        gate_open = ~q.ctrl_eff[`PCC_F_GATE] | chan_pick(q.ev_b, q.ctrl_eff[`PCC_F_TSEL]);
        // Clock source follows the software mode field, so it is valid during reset
        case (q.ctrl[`PCC_F_MODE])
            `PCC_MODE_EXTS: ctr_tick = s0_rise & gate_open;
            `PCC_MODE_EXTQ: ctr_tick = (s0_rise | s0_fall) & gate_open;
            default: ctr_tick = lf_rise & gate_open;
        endcase
        down = q.ctrl_eff[`PCC_F_CNTDIR] ^ (q.ctrl_eff[`PCC_F_S1CDIR] & ~s1_src);
        cnt_pulse = 1'b0;
        edge_now = 1'b0;

        // ****************************************
        // Input decode per mode
        // ****************************************
        case (mode)
            `PCC_MODE_OVS: begin
                if (ctr_tick) begin
                    d.samp_last = s0_src;
                    if (s0_src != q.samp_last) begin
                        d.stab = 3'h0;
                    end else if (q.stab != `PCC_PULSE_FILTER_ENABLE_STABLE) begin
                        d.stab = q.stab + 3'h1;
                    end
                    // Five equal samples in a row before the level passes
                    if (!q.ctrl_eff[`PCC_F_PULSE_FILTER_ENABLE] || d.stab == `PCC_PULSE_FILTER_ENABLE_STABLE) begin
                        d.pulse_filter_enable = s0_src;
                    end
                    edge_now = (d.pulse_filter_enable != q.pulse_filter_enable) && (d.pulse_filter_enable ^ q.ctrl_eff[`PCC_F_EDGE]);
                    cnt_pulse = edge_now;
                end
            end
            `PCC_MODE_EXTS: begin
                cnt_pulse = s0_rise & gate_open;
            end
            `PCC_MODE_EXTQ: begin
                if (s0_rise & gate_open) begin
                    d.qa = s1_src;
                end
                // Equal samples on both edges are a reversal glitch and do not count
                if (s0_fall && gate_open && (s1_src != q.qa)) begin
                    cnt_pulse = 1'b1;
                    down = q.qa ^ q.ctrl_eff[`PCC_F_EDGE];
                end
            end
            default: begin
                cnt_pulse = 1'b0;
            end
        endcase
        if (cnt_pulse) begin
            d.dir = down;
            if (quad && (down != q.dir)) begin
                hw_set[`PCC_I_DC] = 1'b1;
            end
        end

        // ****************************************
        // Main and secondary counters
        // ****************************************
        tcc_on = q.ctrl_eff[`PCC_F_CC_TRIGGER_MODE] != 2'h0;
        if (cnt_pulse) begin
            if (!down && tcc_on) begin
                if (q.cnt == `PCC_CNT_MAX) begin
                    hw_set[`PCC_I_OF] = 1'b1;
                end else begin
                    d.cnt = q.cnt + 16'h0001;
                end
            end else if (!down) begin
                if (q.cnt == q.top) begin
                    d.cnt = 16'h0000;
                    hw_set[`PCC_I_OF] = 1'b1;
                end else begin
                    d.cnt = q.cnt + 16'h0001;
                end
            end else if (q.cnt == 16'h0000) begin
                d.cnt = q.top;
                hw_set[`PCC_I_UF] = 1'b1;
            end else begin
                d.cnt = q.cnt - 16'h0001;
            end
            if (q.ctrl_eff[`PCC_F_AUXEV] == 2'h3 || q.ctrl_eff[`PCC_F_AUXEV] == {down, ~down}) begin
                if (q.aux == q.top) begin
                    d.aux = 16'h0000;
                    hw_set[`PCC_I_AUXOF] = 1'b1;
                end else begin
                    d.aux = q.aux + 16'h0001;
                end
            end
        end

        // ****************************************
        // Triggered compare and clear
        // ****************************************
        msk = (4'h1 << q.ctrl_eff[`PCC_F_CC_PRESCALER]) - 4'h1;
        trig = chan_pick(q.ev_b, q.ctrl_eff[`PCC_F_TSEL]) ^ q.ctrl_eff[`PCC_F_TPOL];
        d.trig_prev = trig;
        case (q.ctrl_eff[`PCC_F_CC_TRIGGER_MODE])
            `PCC_TCC_LF: begin
                cc_raw = lf_rise && gate_open && ((q.presc & msk[2:0]) == msk[2:0]);
            end
            `PCC_TCC_EV: begin
                cc_raw = trig & ~q.trig_prev;
            end
            default: begin
                cc_raw = 1'b0;
            end
        endcase
        if (lf_rise && gate_open) begin
            d.presc = q.presc + 3'h1;
        end
        // A trigger that meets a count pulse waits one cycle
        cc_req = cc_raw | q.cc_pend;
        cc_fire = cc_req & ~cnt_pulse & tcc_on;
        d.cc_pend = cc_req & cnt_pulse & tcc_on;
        match = cmp_hit(q.ctrl_eff[`PCC_F_CC_COMPARE_MODE], q.cnt, q.top);
        if (cc_fire) begin
            d.cnt = 16'h0000;
            d.cmp_out = match;
            hw_set[`PCC_I_CM] = match;
        end

        // ****************************************
        // Commit of written values into the counter domain
        // ****************************************
        commit = 1'b0;
        if (ctr_tick && !dom_rst && !q.freeze && (q.busy != 3'h0)) begin
            if (q.sync_cnt == `PCC_SYNC_EDGES - 2'h1) begin
                commit = 1'b1;
                d.sync_cnt = 2'h0;
                d.busy = 3'h0;
                if (q.busy[`PCC_B_CTRL]) begin
                    d.ctrl_eff = q.ctrl;
                    // New polarity must not look like a trigger edge
                    d.trig_prev = chan_pick(q.ev_b, q.ctrl[`PCC_F_TSEL]) ^ q.ctrl[`PCC_F_TPOL];
                end
                if (q.busy[`PCC_B_TOPB]) begin
                    d.top = q.topb;
                end
                if (q.busy[`PCC_B_CMD]) begin
                    d.cnt = 16'h0000;
                end
            end else begin
                d.sync_cnt = q.sync_cnt + 2'h1;
            end
        end

        // ****************************************
        // Domain resets
        // ****************************************
        if (q.ctrl[`PCC_F_DOMAIN_RESET_BIT]) begin
            d.rel = 2'h0;
        end else if (ctr_tick && q.rel != `PCC_REL_EDGES) begin
            d.rel = q.rel + 2'h1;
        end
        if (q.ctrl[`PCC_F_AUXRST] || dom_rst) begin
            d.aux_rel = 2'h0;
        end else if (ctr_tick && q.aux_rel != `PCC_REL_EDGES) begin
            d.aux_rel = q.aux_rel + 2'h1;
        end
        if (dom_rst) begin
            d.cnt = 16'h0000;
            d.top = `PCC_TOP_RST;
            d.ctrl_eff = 32'h0000_0000;
            d.cmp_out = 1'b0;
            d.presc = 3'h0;
            d.cc_pend = 1'b0;
            d.dir = 1'b0;
            d.sync_cnt = 2'h0;
        end
        if (aux_rst) begin
            d.aux = 16'h0000;
        end

        // ****************************************
        // APB slave, one wait state
        // ****************************************
        wr = psel_in & penable_in & q.pready & pwrite_in;
        wr_ctrl = wr && paddr_in == `PCC_A_CTRL;
        d.pready = psel_in & penable_in & ~q.pready;
        rd_ok = 1'b1;
        d.prdata = 32'h0000_0000;
        case (paddr_in)
            `PCC_A_CTRL: d.prdata = q.ctrl;
            `PCC_A_CMD: d.prdata = 32'h0000_0000;
            `PCC_A_STATUS: d.prdata = {31'h0000_0000, q.dir};
            `PCC_A_CNT: d.prdata = {16'h0000, q.cnt};
            `PCC_A_TOP: d.prdata = {16'h0000, q.top};
            `PCC_A_TOPB: d.prdata = {16'h0000, q.topb};
            `PCC_A_IF: d.prdata = {27'h000_0000, q.iflags};
            `PCC_A_IFS: d.prdata = 32'h0000_0000;
            `PCC_A_IFC: d.prdata = 32'h0000_0000;
            `PCC_A_IEN: d.prdata = {27'h000_0000, q.ien};
            `PCC_A_ROUTE: d.prdata = {30'h0000_0000, q.route};
            `PCC_A_FREEZE: d.prdata = {31'h0000_0000, q.freeze};
            `PCC_A_SYNC: d.prdata = {29'h0000_0000, q.busy};
            `PCC_A_AUX: d.prdata = {16'h0000, q.aux};
            `PCC_A_INPUT: d.prdata = {26'h000_0000, q.inp};
            default: rd_ok = 1'b0;
        endcase
        d.pslverr = psel_in & penable_in & ~q.pready & ~rd_ok;
        if (!d.pready || pwrite_in) begin
            d.prdata = 32'h0000_0000;
        end
        // Hardware set wins over a software clear in the same cycle
        d.iflags = (q.iflags & ~((wr && paddr_in == `PCC_A_IFC) ? pwdata_in[4:0] : 5'h00))
                   | ((wr && paddr_in == `PCC_A_IFS) ? pwdata_in[4:0] : 5'h00) | hw_set;
        if (wr) begin
            case (paddr_in)
                `PCC_A_CTRL: begin
                    d.ctrl = pwdata_in;
                    d.busy[`PCC_B_CTRL] = 1'b1;
                    d.sync_cnt = 2'h0;
                end
                `PCC_A_CMD: begin
                    d.busy[`PCC_B_CMD] = pwdata_in[0];
                    d.sync_cnt = 2'h0;
                end
                `PCC_A_TOPB: begin
                    d.topb = pwdata_in[15:0];
                    d.busy[`PCC_B_TOPB] = 1'b1;
                    d.sync_cnt = 2'h0;
                end
                `PCC_A_IEN: d.ien = pwdata_in[4:0];
                `PCC_A_ROUTE: d.route = pwdata_in[1:0];
                `PCC_A_FREEZE: d.freeze = pwdata_in[0];
                `PCC_A_AUX: d.aux = pwdata_in[15:0];
                `PCC_A_INPUT: d.inp = pwdata_in[5:0];
                default: d.freeze = q.freeze;
            endcase
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q <= '0;
            q.top <= `PCC_TOP_RST;
            q.rel <= `PCC_REL_EDGES;
            q.aux_rel <= `PCC_REL_EDGES;
        end else begin
            q <= d;
        end
    end

    assign prdata_out = q.prdata;
    assign pready_out = q.pready;
    assign pslverr_out = q.pslverr;
    assign compare_event_out = q.cmp_out;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    property p_cc_clear;
        cc_fire && !dom_rst && !commit |=> q.cnt == 16'h0000;
    endproperty
    a_cc_clear: assert property (p_cc_clear) else $error("count not cleared");
    property p_match_out;
        cc_fire && !dom_rst |=> compare_event_out == $past(match) && (q.iflags[`PCC_I_CM]
                                || !$past(match));
    endproperty
    a_match_out: assert property (p_match_out) else $error("match output wrong");
    property p_defer;
        cc_raw && cnt_pulse && tcc_on && !dom_rst |=> q.cc_pend ##1 !q.cc_pend;
    endproperty
    a_defer: assert property (p_defer) else $error("trigger not deferred");
    property p_uf;
        cnt_pulse && down && q.cnt == 16'h0000 && !dom_rst && !commit && !cc_fire
            |=> q.cnt == $past(q.top) && q.iflags[`PCC_I_UF];
    endproperty
    a_uf: assert property (p_uf) else $error("underflow wrong");
    property p_of;
        cnt_pulse && !down && !tcc_on && q.cnt == q.top && !dom_rst && !commit
            |=> q.cnt == 16'h0000 && q.iflags[`PCC_I_OF];
    endproperty
    a_of: assert property (p_of) else $error("overflow wrong");
    property p_sat;
        cnt_pulse && !down && tcc_on && q.cnt == `PCC_CNT_MAX && !dom_rst && !commit
            |=> q.cnt == `PCC_CNT_MAX && q.iflags[`PCC_I_OF];
    endproperty
    a_sat: assert property (p_sat) else $error("saturation wrong");
    property p_rst_hold;
        $fell(q.ctrl[`PCC_F_DOMAIN_RESET_BIT]) |-> dom_rst [*2] ##1 (q.cnt == 16'h0000 || !dom_rst);
    endproperty
    a_rst_hold: assert property (p_rst_hold) else $error("early release");
    property p_busy;
        wr_ctrl |=> q.busy[`PCC_B_CTRL] && q.ctrl_eff == $past(q.ctrl_eff) || $past(dom_rst);
    endproperty
    a_busy: assert property (p_busy) else $error("busy not raised");
    property p_commit;
        commit |-> ctr_tick && q.sync_cnt == 2'h1 ##1 q.busy == 3'h0 || $past(wr);
    endproperty
    a_commit: assert property (p_commit) else $error("commit timing wrong");
    property p_dirchg;
        cnt_pulse && quad && down != q.dir && !dom_rst |=> q.iflags[`PCC_I_DC];
    endproperty
    a_dirchg: assert property (p_dirchg) else $error("direction flag missing");

    c_match: cover property (cc_fire && match);
    c_of: cover property (cnt_pulse && !down && q.cnt == q.top);
    c_commit: cover property (commit);
    c_quad: cover property (cnt_pulse && quad);
endmodule : pcc_pulse_counter

// [verif/pcc_encoder.sv]
// Pulse sensor model driving the counter's input pins
`timescale 1ns/1ps
module pcc_encoder (
    input wire logic clk_in,
    input wire logic lf_in,
    output logic first_out,
    output logic second_out
);
    initial begin
        first_out = 1'b0;
        second_out = 1'b1;
    end
    // Levels held whole slow ticks; a short hold is what the filter must reject
    task automatic pulses(input int n, input int hold);
        repeat (n) begin
            repeat (hold) @(posedge lf_in);
            @(posedge clk_in);
            first_out <= 1'b1;
            repeat (hold) @(posedge lf_in);
            @(posedge clk_in);
            first_out <= 1'b0;
        end
        repeat (3) @(posedge lf_in);
        @(posedge clk_in);
    endtask : pulses
    // One quadrature cycle per step; second input toggles while first is high
    task automatic quad(input int n, input logic dn);
        repeat (n) begin
            second_out <= dn;
            repeat (4) @(posedge clk_in);
            first_out <= 1'b1;
            repeat (4) @(posedge clk_in);
            second_out <= ~dn;
            repeat (4) @(posedge clk_in);
            first_out <= 1'b0;
            repeat (4) @(posedge clk_in);
        end
    endtask : quad
endmodule : pcc_encoder

// [verif/tb_top.sv]
// Self-checking bench for the pulse counter
`timescale 1ns/1ps
`include "pcc_params.svh"
module tb_top;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0;
    logic [31:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    logic low_freq_clock_in = 1'b0;
    logic first_pulse_input_in;
    logic second_pulse_input_in;
    logic [5:0] event_channel_in = 6'h00;
    logic compare_event_out;
    logic err;
    logic [31:0] rd;
    int fails = 0;
    int checks = 0;
    always #50 clk_in = ~clk_in;
    // Slow tick edges fall on falling bus clock edges, between rising ones
    always #15600 low_freq_clock_in = ~low_freq_clock_in;
    pcc_pulse_counter dut (.*);
    pcc_encoder enc (.clk_in(clk_in), .lf_in(low_freq_clock_in),
        .first_out(first_pulse_input_in), .second_out(second_pulse_input_in));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 50);
        if (n == 50) fails++;
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_in);
    endtask : apb
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rd_chk
    // Poll instead of timing it: commits wait on slow ticks
    task automatic wait_sync();
        int n;
        n = 0;
        do begin
            apb(1'b0, `PCC_A_SYNC, 32'h0);
            n++;
        end while (rd !== 32'h0 && n < 800);
        chk(rd, 32'h0);
    endtask : wait_sync
    task automatic t_reset();
        rd_chk(`PCC_A_CTRL, 32'h0);
        rd_chk(`PCC_A_TOP, 32'h0000_00FF);
        apb(1'b1, `PCC_A_TOP, 32'h0000_1234);
        rd_chk(`PCC_A_TOP, 32'h0000_00FF);
        apb(1'b0, 8'h34, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, `PCC_A_TOPB, 32'h0000_0002);
        rd_chk(`PCC_A_SYNC, 32'h0000_0004);
        wait_sync();
        rd_chk(`PCC_A_TOP, 32'h0000_0002);
    endtask : t_reset
    task automatic t_wrap();
        apb(1'b1, `PCC_A_CTRL, {30'h0, `PCC_MODE_OVS});
        wait_sync();
        enc.pulses(2, 2);
        rd_chk(`PCC_A_CNT, 32'h2);
        enc.pulses(1, 2);
        rd_chk(`PCC_A_CNT, 32'h0);
        rd_chk(`PCC_A_IF, 32'h2);
        apb(1'b1, `PCC_A_IFC, 32'h0000_001F);
        apb(1'b1, `PCC_A_CTRL, 32'h0000_0005);
        wait_sync();
        enc.pulses(1, 2);
        rd_chk(`PCC_A_CNT, 32'h2);
        rd_chk(`PCC_A_IF, 32'h1);
    endtask : t_wrap
    task automatic t_filter();
        apb(1'b1, `PCC_A_CTRL, 32'h0000_0011);
        wait_sync();
        enc.pulses(1, 4);
        rd_chk(`PCC_A_CNT, 32'h2);
        enc.pulses(1, 5);
        rd_chk(`PCC_A_CNT, 32'h0);
    endtask : t_filter
    task automatic t_cc();
        logic [31:0] c;
        for (int ch = 0; ch < 6; ch++) begin
            c = 32'h0;
            c[`PCC_F_TSEL] = 3'(ch);
            c[`PCC_F_TPOL] = (ch > 2);
            c[`PCC_F_CC_COMPARE_MODE] = 2'(ch % 3);
            c[`PCC_F_CC_TRIGGER_MODE] = `PCC_TCC_EV;
            c[`PCC_F_MODE] = `PCC_MODE_OVS;
            apb(1'b1, `PCC_A_CTRL, c | 32'h20);
            rd_chk(`PCC_A_TOP, 32'h0000_00FF);
            apb(1'b1, `PCC_A_IFC, 32'h0000_001F);
            apb(1'b1, `PCC_A_CTRL, c);
            wait_sync();
            repeat (3) @(posedge low_freq_clock_in);
            @(posedge clk_in);
            rd_chk(`PCC_A_IF, 32'h0);
            enc.pulses(1, 2);
            event_channel_in <= 6'(1 << ((ch + 1) % 6));
            repeat (20) @(posedge clk_in);
            rd_chk(`PCC_A_CNT, 32'h1);
            event_channel_in <= 6'(1 << ch);
            repeat (20) @(posedge clk_in);
            if (ch > 2) begin
                rd_chk(`PCC_A_CNT, 32'h1);
            end
            event_channel_in <= 6'h00;
            repeat (20) @(posedge clk_in);
            rd_chk(`PCC_A_CNT, 32'h0);
            chk({31'h0, compare_event_out}, {31'h0, ch % 3 == 0});
            rd_chk(`PCC_A_IF, (ch % 3 == 0) ? 32'h4 : 32'h0);
        end
    endtask : t_cc
    task automatic t_lf();
        int n;
        n = 0;
        apb(1'b1, `PCC_A_CTRL, 32'h0044_0020);
        apb(1'b1, `PCC_A_CTRL, 32'h0044_0000);
        wait_sync();
        do begin
            apb(1'b0, `PCC_A_IF, 32'h0);
            n++;
        end while (rd[`PCC_I_CM] !== 1'b1 && n < 400);
        apb(1'b1, `PCC_A_IFC, 32'h0000_001F);
        @(posedge low_freq_clock_in);
        repeat (20) @(posedge clk_in);
        rd_chk(`PCC_A_IF, 32'h0);
        @(posedge low_freq_clock_in);
        repeat (20) @(posedge clk_in);
        rd_chk(`PCC_A_IF, 32'h4);
    endtask : t_lf
    task automatic t_gate();
        apb(1'b1, `PCC_A_CTRL, 32'h4800_0020);
        apb(1'b1, `PCC_A_CTRL, 32'h4800_0000);
        event_channel_in <= 6'h04;
        wait_sync();
        event_channel_in <= 6'h00;
        apb(1'b1, `PCC_A_TOPB, 32'h0000_0033);
        repeat (3) @(posedge low_freq_clock_in);
        @(posedge clk_in);
        rd_chk(`PCC_A_SYNC, 32'h0000_0004);
        rd_chk(`PCC_A_TOP, 32'h0000_00FF);
        event_channel_in <= 6'h04;
        wait_sync();
        rd_chk(`PCC_A_TOP, 32'h0000_0033);
    endtask : t_gate
    task automatic t_quad();
        apb(1'b1, `PCC_A_CTRL, 32'h0000_0023);
        apb(1'b1, `PCC_A_CTRL, {30'h0, `PCC_MODE_EXTQ});
        enc.quad(2, 1'b0);
        rd_chk(`PCC_A_SYNC, 32'h0);
        enc.quad(3, 1'b0);
        apb(1'b1, `PCC_A_IFC, 32'h0000_001F);
        enc.quad(1, 1'b1);
        rd_chk(`PCC_A_CNT, 32'h2);
        rd_chk(`PCC_A_IF, 32'h8);
        rd_chk(`PCC_A_STATUS, 32'h1);
    endtask : t_quad
    task automatic wrap_up();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (10) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_reset();
        t_wrap();
        t_filter();
        t_cc();
        t_lf();
        t_gate();
        t_quad();
        wrap_up();
    end
    // About one and a half times the expected run, still under the cycle budget
    initial begin
        #8000000;
        fails++;
        wrap_up();
    end
endmodule : tb_top
